// [hw/ident_rom_regs.svh]
`ifndef IDENT_ROM_REGS_SVH
`define IDENT_ROM_REGS_SVH

// ****************************************************************
// addresses
// ****************************************************************
`define ADDR_TECH_TWO        16'h8019
`define ADDR_SIGNAL_CODE     16'h801A
`define ADDR_MAX_OUT_POWER   16'h801B
`define ADDR_MAX_IN_POWER    16'h801C
`define ADDR_MAX_POWER       16'h801D
`define ADDR_MAX_LOW_POWER   16'h801E
`define ADDR_MAX_CASE_TEMP   16'h801F
`define ADDR_MIN_CASE_TEMP   16'h8020
`define ADDR_MAKER_NAME      16'h8021
`define ADDR_ORG_ID          16'h8031
`define ADDR_MAKER_PART      16'h8034
`define ADDR_MAKER_SERIAL    16'h8044
`define ADDR_DATE_CODE       16'h8054
`define ADDR_LOT_CODE        16'h805C
`define ADDR_EQUIP_ID        16'h805E
`define ADDR_HW_SPEC_REV     16'h8068
`define ADDR_MGMT_SPEC_REV   16'h8069
`define ADDR_MODULE_HW_VER   16'h806A
`define ADDR_MODULE_FW_VER   16'h806C
`define ADDR_MON_TYPE        16'h806E
`define ADDR_MON_CAP_MODULE  16'h806F
`define ADDR_MON_CAP_LANE    16'h8070
`define ADDR_ENH_OPTIONS     16'h8071
`define ADDR_POWER_UP_TIME   16'h8072
`define ADDR_TX_ON_TIME      16'h8073
`define ADDR_HOST_SIG_SPEC   16'h8074
`define ADDR_HEAT_SINK       16'h8075
`define ADDR_FIRST           16'h8019
`define ADDR_LAST            16'h8075

// ****************************************************************
// values and fields
// ****************************************************************
`define ASCII_SPACE          8'h20
`define TEMP_UNDEFINED       8'h80
`define TEMP_MAX_VALID       8'sh7F
`define TEMP_MIN_VALID       (-8'sh7F)
`define MIN_SECONDS          8'h01
`define SPEC_MULTIPLE        8'hFF
`define SPEC_HUNDRED_GIG     8'h01
`define DET_UNDEF            2'h0
`define DET_PHOTODIODE       2'h1
`define DET_AVALANCHE        2'h2
`define DET_AMP_PHOTODIODE   2'h3
`define CODING_RESERVED_LO   4'h7
`define CODING_RESERVED_HI   4'hA
`define CODING_LAST          4'hD
`define TECH_WL_CTRL_BIT     7
`define TECH_COOLED_BIT      6
`define TECH_TUNABLE_BIT     5
`define TECH_ATTEN_BIT       4
`define TECH_CDR_BIT         1
`define MON_TYPE_RX_BIT      3
`define MON_TYPE_TX_BIT      2

`endif

// [hw/ident_rom_pkg.sv]
package ident_rom_pkg;
    typedef enum logic [1:0] {
        DETECTOR_UNDEF,
        DETECTOR_PHOTODIODE,
        DETECTOR_AVALANCHE,
        DETECTOR_AMP_PHOTODIODE
    } detector_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [0:0] {
        READ_IDLE,
        READ_DONE
    } read_state_t;
endpackage : ident_rom_pkg

// [hw/ident_rom_mem.sv]
`timescale 1ns/100ps
`include "ident_rom_regs.svh"

module ident_rom_mem
    import ident_rom_pkg::*;
#(
    parameter int DEPTH = 93,
    parameter int AW    = 7
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          arst_n,
    // contents and read
    input  wire logic [DEPTH*8-1:0] image,
    input  wire logic [AW-1:0] index,
    input  wire logic          readEn,
    output      logic [7:0]    readData
);

    // ****************************************************************
    // registered read
    // ****************************************************************
    // contents come from a constant image, so there is no write path
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            readData <= 8'h00;
        end else if (readEn) begin
            if (32'(index) < DEPTH) begin
                readData <= image[32'(index)*8 +: 8];
            end else begin
                readData <= 8'h00;
            end
        end
    end

endmodule : ident_rom_mem

// [hw/ident_rom.sv]
`timescale 1ns/100ps
`include "ident_rom_regs.svh"

module ident_rom
    import ident_rom_pkg::*;
#(
    parameter logic [7:0]   TECH_FLAGS      = 8'h00,
    parameter detector_t    DETECTOR        = DETECTOR_PHOTODIODE,
    parameter logic [1:0]   MODULATION      = 2'h1,
    parameter logic [3:0]   CODING          = 4'h0,
    parameter logic [7:0]   OUT_POWER       = 8'h00,
    parameter logic [7:0]   IN_POWER        = 8'h00,
    parameter logic [7:0]   POWER           = 8'h00,
    parameter logic [7:0]   LOW_POWER       = 8'h00,
    parameter logic [7:0]   CASE_TEMP_MAX   = `TEMP_UNDEFINED,
    parameter logic [7:0]   CASE_TEMP_MIN   = `TEMP_UNDEFINED,
    // arbitrary neutral identity text and codes
    parameter logic [127:0] MAKER_NAME      = "EXAMPLE",
    parameter logic [23:0]  ORG_ID          = 24'h000000,
    parameter logic [127:0] MAKER_PART      = "PART0",
    parameter logic [127:0] MAKER_SERIAL    = "SN0",
    parameter logic [63:0]  DATE_CODE       = "20000101",
    parameter logic [15:0]  LOT_CODE        = "00",
    parameter logic [79:0]  EQUIP_ID        = "0000000000",
    parameter logic [7:0]   HW_SPEC_REV     = 8'h00,
    parameter logic [7:0]   MGMT_SPEC_REV   = 8'h00,
    parameter logic [15:0]  HW_VERSION      = 16'h0000,
    parameter logic [15:0]  FW_VERSION      = 16'h0000,
    parameter logic [7:0]   MON_TYPE        = 8'h00,
    parameter logic [7:0]   MON_CAP_MODULE  = 8'h00,
    parameter logic [7:0]   MON_CAP_LANE    = 8'h00,
    parameter logic [7:0]   ENH_OPTIONS     = 8'h00,
    parameter logic [7:0]   POWER_UP_SEC    = 8'h01,
    parameter logic [7:0]   TX_ON_SEC       = 8'h01,
    parameter logic [7:0]   HOST_SIG_SPEC   = `SPEC_HUNDRED_GIG,
    parameter logic [7:0]   HEAT_SINK       = 8'h00
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // register access
    input  wire logic [15:0] regAddr,
    input  wire logic        regRead,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWriteData,
    output      logic [7:0]  regReadData,
    output      logic        regReadValid,
    output      logic        regHit
);

    localparam int DEPTH = 93;
    localparam int AW    = 7;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // strings arrive as packed literals with the first character high;
    // this reverses them into address order and pads with spaces
    function automatic logic [127:0] text_image(input logic [127:0] s);
        logic [127:0] r;
        int           n;
        int           k;
        r = {16{`ASCII_SPACE}};
        n = 0;
        for (k = 15; k >= 0; k--) begin
            if (s[k*8 +: 8] != 8'h00) begin
                n = k + 1;
                break;
            end
        end
        for (k = 0; k < 16; k++) begin
            if (k < n) begin
                r[k*8 +: 8] = s[(n-1-k)*8 +: 8];
            end
        end
        return r;
    endfunction : text_image

    // multi-byte fields: most significant byte at the lowest address
    function automatic logic [63:0] forward_order(input logic [63:0] v,
                                                  input int          len);
        logic [63:0] r;
        int          k;
        r = 64'h0;
        for (k = 0; k < 8; k++) begin
            if (k < len) begin
                r[k*8 +: 8] = v[(len-1-k)*8 +: 8];
            end
        end
        return r;
    endfunction : forward_order

    // seconds fields never report under one second
    function automatic logic [7:0] at_least_one(input logic [7:0] v);
        return (v < `MIN_SECONDS) ? `MIN_SECONDS : v;
    endfunction : at_least_one

    // temperatures outside -127..+127 fall back to undefined
    function automatic logic [7:0] temp_byte(input logic [7:0] v);
        return (v == `TEMP_UNDEFINED) ? `TEMP_UNDEFINED : v;
    endfunction : temp_byte

    function automatic logic [3:0] coding_field(input logic [3:0] c);
        logic bad;
        bad = (c >= `CODING_RESERVED_LO && c <= `CODING_RESERVED_HI)
              || (c > `CODING_LAST);
        return bad ? 4'h0 : c;
    endfunction : coding_field

    // ****************************************************************
    // byte image
    // ****************************************************************
    logic [7:0]         techTwo;
    logic [7:0]         signalCode;
    logic [7:0]         monType;
    logic [7:0]         monCapModule;
    logic [7:0]         monCapLane;
    logic [7:0]         enhOptions;
    logic [7:0]         hostSpec;
    logic [DEPTH*8-1:0] image;

    always_comb begin
        techTwo = 8'h00;
        techTwo[`TECH_WL_CTRL_BIT] = TECH_FLAGS[`TECH_WL_CTRL_BIT];
        techTwo[`TECH_COOLED_BIT]  = TECH_FLAGS[`TECH_COOLED_BIT];
        techTwo[`TECH_TUNABLE_BIT] = TECH_FLAGS[`TECH_TUNABLE_BIT];
        techTwo[`TECH_ATTEN_BIT]   = TECH_FLAGS[`TECH_ATTEN_BIT];
        techTwo[`TECH_CDR_BIT]     = TECH_FLAGS[`TECH_CDR_BIT];
        techTwo[3:2] = DETECTOR;
        signalCode = {MODULATION, coding_field(CODING), 2'h0};
        monType = 8'h00;
        monType[`MON_TYPE_RX_BIT] = MON_TYPE[`MON_TYPE_RX_BIT];
        monType[`MON_TYPE_TX_BIT] = MON_TYPE[`MON_TYPE_TX_BIT];
        monCapModule = {MON_CAP_MODULE[7:4], 1'b0,
                        MON_CAP_MODULE[2:0]};
        monCapLane = {4'h0, MON_CAP_LANE[3:0]};
        enhOptions = {ENH_OPTIONS[7:5], 2'h0,
                      ENH_OPTIONS[2:0]};
        hostSpec = HOST_SIG_SPEC;
        image = {
            {7'h00, HEAT_SINK[0]},
            hostSpec,
            at_least_one(TX_ON_SEC),
            at_least_one(POWER_UP_SEC),
            enhOptions,
            monCapLane,
            monCapModule,
            monType,
            16'(forward_order({48'h0, FW_VERSION}, 2)),
            16'(forward_order({48'h0, HW_VERSION}, 2)),
            MGMT_SPEC_REV,
            HW_SPEC_REV,
            // last two characters sit above the first eight
            16'(forward_order({48'h0, EQUIP_ID[15:0]}, 2)),
            forward_order(EQUIP_ID[79:16], 8),
            16'(forward_order({48'h0, LOT_CODE}, 2)),
            forward_order(DATE_CODE, 8),
            text_image(MAKER_SERIAL),
            text_image(MAKER_PART),
            24'(forward_order({40'h0, ORG_ID}, 3)),
            text_image(MAKER_NAME),
            temp_byte(CASE_TEMP_MIN),
            temp_byte(CASE_TEMP_MAX),
            LOW_POWER,
            POWER,
            IN_POWER,
            OUT_POWER,
            signalCode,
            techTwo
        };
    end

    // ****************************************************************
    // access
    // ****************************************************************
    logic          inRange;
    logic [AW-1:0] index;
    logic [7:0]    memData;
    logic          hitPending;

    assign inRange = (regAddr >= `ADDR_FIRST) && (regAddr <= `ADDR_LAST);
    assign index   = AW'(regAddr - `ADDR_FIRST);

    ident_rom_mem #(
        .DEPTH    (DEPTH),
        .AW       (AW)
    ) u_mem (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .image    (image),
        .index    (index),
        .readEn   (regRead && inRange),
        .readData (memData)
    );

    // writes are accepted on the port but never reach storage
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hitPending <= 1'b0;
        end else begin
            hitPending <= regRead && inRange && !regWrite;
        end
    end

    // one extra stage keeps every output straight off a flip-flop
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regReadValid <= 1'b0;
            regHit       <= 1'b0;
            regReadData  <= 8'h00;
        end else begin
            regReadValid <= hitPending;
            regHit       <= hitPending;
            regReadData  <= hitPending ? memData : 8'h00;
        end
    end

    logic unusedWrite;
    assign unusedWrite = ^regWriteData;

endmodule : ident_rom

// [verification/ident_rom_chk.sv]
`timescale 1ns/100ps
`include "ident_rom_regs.svh"

module ident_rom_chk (
    // clock and reset
    input wire logic        mclk,
    input wire logic        arst_n,
    // register access
    input wire logic [15:0] regAddr,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [7:0]  regWriteData,
    input wire logic [7:0]  regReadData,
    input wire logic        regReadValid,
    input wire logic        regHit
);
    // ****************************************************
    // taken reads
    // ****************************************************
    logic take;
    assign take = regRead && !regWrite && regAddr >= `ADDR_FIRST
                  && regAddr <= `ADDR_LAST;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_answer; take |-> ##2 regReadValid && regHit; endproperty
    a_answer: assert property (p_answer)
        else $error("taken read not answered");
    property p_refuse; regRead && !take |-> ##2 !regReadValid;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused read answered");
    property p_spur; regReadValid |-> $past(take, 2); endproperty
    a_spur: assert property (p_spur)
        else $error("answer without request");
    property p_zero; !regReadValid |-> regReadData == 8'h00; endproperty
    a_zero: assert property (p_zero)
        else $error("data not idle");
    property p_hit; regHit == regReadValid; endproperty
    a_hit: assert property (p_hit)
        else $error("hit and valid differ");
    property p_tech; take && regAddr == `ADDR_TECH_TWO
        |-> ##2 !regReadData[0]; endproperty
    a_tech: assert property (p_tech)
        else $error("tech reserved bit set");
    property p_code; take && regAddr == `ADDR_SIGNAL_CODE |-> ##2
        regReadData[1:0] == 2'h0 && !(regReadData[5:2] inside
        {[`CODING_RESERVED_LO:`CODING_RESERVED_HI], 4'hE, 4'hF});
    endproperty
    a_code: assert property (p_code)
        else $error("reserved coding shown");
    property p_lane; take && regAddr == `ADDR_MON_CAP_LANE
        |-> ##2 regReadData[7:4] == 4'h0; endproperty
    a_lane: assert property (p_lane)
        else $error("lane upper bits set");
    property p_secs; take && (regAddr == `ADDR_POWER_UP_TIME ||
        regAddr == `ADDR_TX_ON_TIME) |-> ##2 regReadData != 8'h00;
    endproperty
    a_secs: assert property (p_secs)
        else $error("time below one second");
endmodule : ident_rom_chk

bind ident_rom ident_rom_chk chk (.mclk(mclk), .arst_n(arst_n),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .regReadValid(regReadValid), .regHit(regHit));

// [verification/mgmt_host_model.sv]
`timescale 1ns/100ps

module mgmt_host_model
    import ident_rom_pkg::*;
(
    // clock
    input  wire logic        mclk,
    // register access
    output      logic [15:0] regAddr,
    output      logic        regRead,
    output      logic        regWrite,
    output      logic [7:0]  regWriteData,
    input  wire logic [7:0]  regReadData,
    input  wire logic        regReadValid,
    input  wire logic        regHit
);
    // ****************************************************
    // pipelined access, one request per cycle
    // ****************************************************
    byte_t gotData[$];
    logic  gotValid[$];
    logic  gotHit[$];
    initial begin
        regAddr      = 16'h0000;
        regRead      = 1'b0;
        regWrite     = 1'b0;
        regWriteData = 8'h00;
    end
    // answer of request k is settled at the falling edge k+2
    task automatic access(input logic [15:0] a0, input int n,
                          input logic rd, input logic wr);
        int i;
        gotData.delete();
        gotValid.delete();
        gotHit.delete();
        for (i = 0; i < n + 2; i++) begin
            @(negedge mclk);
            if (i >= 2) begin
                gotData.push_back(regReadData);
                gotValid.push_back(regReadValid);
                gotHit.push_back(regHit);
            end
            regRead      = rd && (i < n);
            regWrite     = wr && (i < n);
            regAddr      = a0 + i[15:0];
            // data changes every cycle so a stuck write shows
            regWriteData = ~regAddr[7:0];
        end
    endtask : access
endmodule : mgmt_host_model

// [verification/ident_rom_test.sv]
`timescale 1ns/100ps
`include "ident_rom_regs.svh"

module ident_rom_test
    import ident_rom_pkg::*;
;
    logic        mclk;
    logic        arst_n;
    logic [15:0] regAddr;
    logic        regRead;
    logic        regWrite;
    logic [7:0]  regWriteData;
    logic [7:0]  regReadData;
    logic        regReadValid;
    logic        regHit;
    int          fail_count = 0;
    int          checked = 0;

    // bank contents under test
    localparam logic [7:0]   CFG_TECH  = 8'hB2;
    localparam logic [3:0]   CFG_CODE  = 4'hB;
    localparam logic [7:0]   CFG_OUTP  = 8'h0A;
    localparam logic [7:0]   CFG_ALL1  = 8'hFF;
    localparam logic [7:0]   CFG_POW   = 8'h01;
    localparam logic [7:0]   CFG_TMAX  = 8'h55;
    localparam logic [127:0] CFG_NAME  = "ACME";
    localparam logic [23:0]  CFG_ORG   = 24'h123456;
    localparam logic [127:0] CFG_SER   = "SN0";
    localparam logic [63:0]  CFG_DATE  = "12345678";
    localparam logic [7:0]   CFG_HWREV = 8'h1A;
    localparam logic [15:0]  CFG_HWVER = 16'h0302;
    localparam logic [7:0]   CFG_ENH   = 8'hE7;
    localparam logic [7:0]   CFG_PUP   = 8'h00;
    localparam logic [7:0]   CFG_TXON  = 8'h05;
    ident_rom #(.TECH_FLAGS(CFG_TECH), .DETECTOR(DETECTOR_AVALANCHE),
        .CODING(CFG_CODE), .OUT_POWER(CFG_OUTP), .IN_POWER(CFG_ALL1),
        .POWER(CFG_POW), .CASE_TEMP_MAX(CFG_TMAX), .MAKER_NAME(CFG_NAME),
        .ORG_ID(CFG_ORG), .MAKER_SERIAL(CFG_SER),
        .DATE_CODE(CFG_DATE), .HW_SPEC_REV(CFG_HWREV),
        .HW_VERSION(CFG_HWVER), .MON_TYPE(CFG_ALL1),
        .MON_CAP_MODULE(CFG_ALL1), .MON_CAP_LANE(CFG_ALL1),
        .ENH_OPTIONS(CFG_ENH), .POWER_UP_SEC(CFG_PUP),
        .TX_ON_SEC(CFG_TXON), .HOST_SIG_SPEC(CFG_ALL1)) uut (
        .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .regHit(regHit));
    mgmt_host_model host (.mclk(mclk), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .regHit(regHit));

    // ****************************************************
    // expected contents, bit 8 marks a checked place
    // ****************************************************
    function automatic logic [8:0] exp_at(input logic [15:0] a);
        logic [31:0] nm;
        logic [23:0] sn;
        nm = "ACME";
        sn = "SN0";
        if (a >= 16'h8021 && a < 16'h8031)
            return {1'b1, a < 16'h8025 ? nm[8*(16'h8024-a) +: 8] : 8'h20};
        if (a >= 16'h8044 && a < 16'h8054)
            return {1'b1, a < 16'h8047 ? sn[8*(16'h8046-a) +: 8] : 8'h20};
        if (a >= 16'h8054 && a < 16'h805C)
            return {1'b1, 8'h31 + a[7:0] - 8'h54};
        case (a)
            16'h8019: return 9'h1BA;
            16'h801A: return 9'h16C;
            16'h801B: return 9'h10A;
            16'h801C: return 9'h1FF;
            16'h801D: return 9'h101;
            16'h801E: return 9'h100;
            16'h801F: return 9'h155;
            16'h8020: return 9'h180;
            16'h8031: return 9'h112;
            16'h8032: return 9'h134;
            16'h8033: return 9'h156;
            16'h8068: return 9'h11A;
            16'h806A: return 9'h103;
            16'h806B: return 9'h102;
            16'h806E: return 9'h10C;
            16'h806F: return 9'h1F7;
            16'h8070: return 9'h10F;
            16'h8071: return 9'h1E7;
            16'h8072: return 9'h101;
            16'h8073: return 9'h105;
            16'h8074: return 9'h1FF;
            default:  return 9'h000;
        endcase
    endfunction : exp_at

    task automatic chk8(input string n, input byte_t e, input byte_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk8
    task automatic chk1(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset;
        @(negedge mclk);
        arst_n = 1'b0;
        repeat (5) @(negedge mclk);
        chk1("reset valid", 1'b0, regReadValid);
        chk8("reset data", 8'h00, regReadData);
        arst_n = 1'b1;
    endtask : t_reset
    // whole bank back to back; a write strobe must refuse every read
    task automatic t_sweep(input logic wr);
        int i;
        logic [8:0] e;
        host.access(`ADDR_FIRST, 93, 1'b1, wr);
        for (i = 0; i < 93; i++) begin
            e = exp_at(`ADDR_FIRST + i[15:0]);
            chk1("valid", !wr, host.gotValid[i]);
            chk1("hit", !wr, host.gotHit[i]);
            if (e[8] || wr)
                chk8("data", wr ? 8'h00 : e[7:0], host.gotData[i]);
        end
    endtask : t_sweep
    task automatic t_edges;
        host.access(16'h8018, 1, 1'b1, 1'b0);
        chk1("below valid", 1'b0, host.gotValid[0]);
        host.access(16'h8076, 1, 1'b1, 1'b0);
        chk1("above valid", 1'b0, host.gotValid[0]);
        chk8("above data", 8'h00, host.gotData[0]);
    endtask : t_edges

    task report_and_stop;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #40000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        arst_n = 1'b0;
        t_reset();
        t_sweep(1'b0);
        t_sweep(1'b1);
        t_edges();
        host.access(`ADDR_FIRST, 93, 1'b0, 1'b1);
        t_reset();
        t_sweep(1'b0);
        t_sweep(1'b0);
        report_and_stop();
    end
endmodule : ident_rom_test
